// ### hw/flash_host.sv
// Avalon-controlled host that issues command sequences to a parallel NOR flash
`timescale 1ns/1ps

module flash_host
	import flash_host_pkg::*;
#(
	parameter int unsigned POLL_LIMIT = `FH_POLL_LIMIT // Poll reads before giving up
) (
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic [2:0]            address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [31:0]           writedata,
	output logic      [31:0]           readdata,
	output logic                       waitrequest,
	output logic      [`FH_ADDR_W-1:0] flash_addr,
	input  wire logic [`FH_DATA_W-1:0] dq_in,
	output logic      [`FH_DATA_W-1:0] dq_out,
	output logic                       dq_oe,
	output logic                       ce_n,
	output logic                       we_n,
	output logic                       oe_n
);

////////////////////////////////////////////////////////////////////////////////
// Sequence tables
	// Number of write cycles each operation issues
	function automatic logic [2:0] op_writes(input logic [3:0] op);
		case (op)
			`FH_OP_RESET, `FH_OP_SUSPEND, `FH_OP_RESUME: op_writes = 3'h1;
			`FH_OP_BYP_PROG, `FH_OP_BYP_EXIT:            op_writes = 3'h2;
			`FH_OP_BYP_ENTER, `FH_OP_AUTOSEL:            op_writes = 3'h3;
			`FH_OP_PROGRAM:                              op_writes = 3'h4;
			`FH_OP_SECT_ERASE, `FH_OP_CHIP_ERASE:        op_writes = 3'h6;
			default:                                     op_writes = 3'h0;
		endcase
	endfunction
	// Operations that end with the polling loop
	function automatic logic op_polls(input logic [3:0] op);
		case (op)
			`FH_OP_PROGRAM, `FH_OP_BYP_PROG, `FH_OP_SECT_ERASE, `FH_OP_CHIP_ERASE,
			`FH_OP_SUSPEND, `FH_OP_RESUME: op_polls = 1'h1;
			default:                       op_polls = 1'h0;
		endcase
	endfunction
	// Erase that may still be suspended
	function automatic logic op_sector(input logic [3:0] op);
		op_sector = (op == `FH_OP_SECT_ERASE) || (op == `FH_OP_RESUME);
	endfunction
	// Address and data of write cycle idx; upper byte zero except on a program data cycle
	function automatic flash_cycle_type cmd_cycle(input logic [3:0] op, input logic [2:0] idx,
			input logic byte_mode, input logic [`FH_ADDR_W-1:0] loc,
			input logic [`FH_DATA_W-1:0] val);
		logic [`FH_ADDR_W-1:0] a1;
		logic [`FH_ADDR_W-1:0] a2;
		logic [7:0]            cd;
		a1 = byte_mode ? `FH_UA1_BYTE : `FH_UA1_WORD;
		a2 = byte_mode ? `FH_UA2_BYTE : `FH_UA2_WORD;
		// Shared unlock pattern: idx 0/3 first unlock, 1/4 second
		cmd_cycle.addr = (idx == 3'h1 || idx == 3'h4) ? a2 : a1;
		cd = (idx == 3'h1 || idx == 3'h4) ? `FH_CD_UNLOCK2 : `FH_CD_UNLOCK1;
		case (op)
			`FH_OP_RESET:   cd = `FH_CD_RESET;
			`FH_OP_SUSPEND: cd = `FH_CD_SUSPEND;
			`FH_OP_RESUME:  cd = `FH_CD_RESUME;
			`FH_OP_BYP_PROG:   cd = idx[0] ? val[7:0] : `FH_CD_PROGRAM;
			`FH_OP_BYP_EXIT:   cd = idx[0] ? `FH_CD_BYP_EXIT2 : `FH_CD_BYP_EXIT1;
			`FH_OP_PROGRAM:    if (idx == 3'h2) cd = `FH_CD_PROGRAM;
			`FH_OP_BYP_ENTER:  if (idx == 3'h2) cd = `FH_CD_BYPASS;
			`FH_OP_AUTOSEL:    if (idx == 3'h2) cd = `FH_CD_AUTOSEL;
			`FH_OP_SECT_ERASE, `FH_OP_CHIP_ERASE: begin
				if (idx == 3'h2) cd = `FH_CD_ERASE_SET;
				if (idx == 3'h5) cd = (op == `FH_OP_CHIP_ERASE) ? `FH_CD_CHIP : `FH_CD_SECTOR;
			end
			default: cd = `FH_CD_RESET;
		endcase
		cmd_cycle.data = {`FH_CD_UPPER, cd};
		// Final cycle of program or sector erase carries the target; sector sits in top bits
		if ((op == `FH_OP_PROGRAM && idx == 3'h3) || (op == `FH_OP_BYP_PROG && idx == 3'h1))
			cmd_cycle = '{addr: loc, data: val};
		if (op == `FH_OP_SECT_ERASE && idx == 3'h5)
			cmd_cycle.addr = loc;
	endfunction
	// Pins for the setup phase of a write cycle
	function automatic flash_pins_type wr_pins(input flash_cycle_type c);
		wr_pins = '{addr: c.addr, dout: c.data, dq_oe: 1'h1, ce_n: 1'h0, we_n: 1'h1,
			oe_n: 1'h1};
	endfunction
	// Pins for a read cycle at loc
	function automatic flash_pins_type rd_pins(input logic [`FH_ADDR_W-1:0] loc);
		rd_pins = '{addr: loc, dout: '0, dq_oe: 1'h0, ce_n: 1'h0, we_n: 1'h1, oe_n: 1'h0};
	endfunction
////////////////////////////////////////////////////////////////////////////////
// State
	state_type             state_reg, state_next;       // Sequencer state
	logic [3:0]            op_reg, op_next;             // Running operation
	logic [2:0]            step_reg, step_next;         // Write cycle index
	logic [2:0]            cnt_reg, cnt_next;           // Strobe and access wait
	logic [31:0]           poll_reg, poll_next;         // Poll reads so far
	logic                  final_reg, final_next;       // Poll done, data read pending
	logic                  limit_reg, limit_next;       // Timing-limit flag seen
	logic                  busy_reg, busy_next;         // Operation in flight
	logic                  done_reg, done_next;         // Last operation ended
	logic                  fail_reg, fail_next;         // Last operation failed
	logic                  refused_reg, refused_next;   // Last command refused
	logic                  bypass_reg, bypass_next;     // Device is in bypass mode
	logic                  susp_reg, susp_next;         // Erase is suspended
	logic                  sreq_reg, sreq_next;         // Suspend wanted during erase
	logic                  byte_reg, byte_next;         // Byte-mode addressing
	logic [`FH_ADDR_W-1:0] addr_reg, addr_next;         // Target location
	logic [`FH_DATA_W-1:0] data_reg, data_next;         // Value to program
	logic [`FH_DATA_W-1:0] rdata_reg, rdata_next;       // Last word read
	flash_pins_type        pins_reg, pins_next;         // Flash pin drivers
	logic [31:0]           rd_reg, rd_next;             // Avalon read data
	logic                  wait_reg, wait_next;         // Avalon waitrequest
	logic [31:0]           status_word;                 // Status register image
	logic [3:0]            wop;                         // Opcode being written
	logic                  go;                          // Start accepted
	logic                  exp_bit;                     // Polling bit when done
	assign readdata    = rd_reg;
	assign waitrequest = wait_reg;
	assign flash_addr  = pins_reg.addr;
	assign dq_out      = pins_reg.dout;
	assign dq_oe       = pins_reg.dq_oe;
	assign ce_n        = pins_reg.ce_n;
	assign we_n        = pins_reg.we_n;
	assign oe_n        = pins_reg.oe_n;
	assign wop         = writedata[3:0];
	// Program waits for the true bit, erase and suspend for a one
	assign exp_bit = (op_reg == `FH_OP_PROGRAM || op_reg == `FH_OP_BYP_PROG) ?
		data_reg[`FH_POLL_BIT] : 1'h1;
	// Status register image
	always_comb begin
		status_word                  = '0;
		status_word[`FH_ST_BUSY]     = busy_reg;
		status_word[`FH_ST_DONE]     = done_reg;
		status_word[`FH_ST_FAIL]     = fail_reg;
		status_word[`FH_ST_LIMIT]    = limit_reg;
		status_word[`FH_ST_REFUSED]  = refused_reg;
		status_word[`FH_ST_BYPASS]   = bypass_reg;
		status_word[`FH_ST_SUSP]     = susp_reg;
		status_word[`FH_ST_SUSP_REQ] = sreq_reg;
	end
////////////////////////////////////////////////////////////////////////////////
// Next-state logic: Avalon slave and flash sequencer
	always_comb begin
		state_next = state_reg;  op_next = op_reg;        step_next = step_reg;
		cnt_next = cnt_reg;      poll_next = poll_reg;    final_next = final_reg;
		limit_next = limit_reg;  busy_next = busy_reg;    done_next = done_reg;
		fail_next = fail_reg;    refused_next = refused_reg;
		bypass_next = bypass_reg; susp_next = susp_reg;   sreq_next = sreq_reg;
		byte_next = byte_reg;    addr_next = addr_reg;    data_next = data_reg;
		rdata_next = rdata_reg;  pins_next = pins_reg;    rd_next = rd_reg;
		wait_next = 1'h1;
		go = 1'h0;
		// One wait cycle per access; read data latched for the release edge
		if ((read || write) && wait_reg) begin
			wait_next = 1'h0;
			case (address)
				`FH_REG_CMD:    rd_next = {28'h000_0000, op_reg};
				`FH_REG_CTRL:   rd_next = {31'h0000_0000, byte_reg};
				`FH_REG_ADDR:   rd_next = {13'h0000, addr_reg};
				`FH_REG_DATA:   rd_next = {16'h0000, data_reg};
				`FH_REG_STATUS: rd_next = status_word;
				`FH_REG_RDATA:  rd_next = {16'h0000, rdata_reg};
				default:        rd_next = 32'h0000_0000;
			endcase
		end
		// Writes take effect on the edge that ends the acknowledge cycle
		if (write && !wait_reg) begin
			case (address)
				`FH_REG_CTRL: byte_next = writedata[`FH_CTRL_BYTE];
				`FH_REG_ADDR: addr_next = writedata[`FH_ADDR_W-1:0];
				`FH_REG_DATA: data_next = writedata[`FH_DATA_W-1:0];
				`FH_REG_CMD: begin
					if (wop == `FH_OP_SUSPEND && busy_reg && op_sector(op_reg))
						sreq_next = 1'h1;
					else if (busy_reg || wop > `FH_OP_AUTOSEL ||
							(wop == `FH_OP_SUSPEND) ||
							(wop == `FH_OP_BYP_PROG && !bypass_reg) ||
							(wop == `FH_OP_RESUME && !susp_reg) ||
							(wop == `FH_OP_SECT_ERASE && susp_reg) ||
							(wop == `FH_OP_CHIP_ERASE && susp_reg))
						refused_next = 1'h1;
					else
						go = 1'h1;
				end
				default: ;
			endcase
		end
		case (state_reg)
			ST_IDLE: begin
				if (go) begin
					op_next = wop;      step_next = 3'h0;    poll_next = '0;
					final_next = 1'h0;  limit_next = 1'h0;   busy_next = 1'h1;
					done_next = 1'h0;   fail_next = 1'h0;    refused_next = 1'h0;
					if (op_writes(wop) != 3'h0) begin
						pins_next  = wr_pins(cmd_cycle(wop, 3'h0, byte_reg, addr_reg, data_reg));
						state_next = ST_W_SETUP;
					end else begin
						pins_next  = rd_pins(addr_reg);
						state_next = ST_R_SETUP;
					end
				end
			end
			ST_W_SETUP: begin
				pins_next.we_n = 1'h0;
				cnt_next       = `FH_WE_CYC - 3'h1;
				state_next     = ST_W_LOW;
			end
			ST_W_LOW: begin
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h0) begin
					pins_next.we_n = 1'h1;
					state_next     = ST_W_HIGH;
				end
			end
			ST_W_HIGH: begin
				// Data stays driven one cycle past the rising strobe
				pins_next.ce_n  = 1'h1;
				pins_next.dq_oe = 1'h0;
				state_next      = ST_W_END;
			end
			ST_W_END: begin
				if (step_reg + 3'h1 < op_writes(op_reg)) begin
					step_next  = step_reg + 3'h1;
					pins_next  = wr_pins(cmd_cycle(op_reg, step_reg + 3'h1, byte_reg,
						addr_reg, data_reg));
					state_next = ST_W_SETUP;
				end else begin
					case (op_reg)
						`FH_OP_BYP_ENTER: bypass_next = 1'h1;
						`FH_OP_BYP_EXIT:  bypass_next = 1'h0;
						`FH_OP_SUSPEND:   susp_next   = 1'h1;
						`FH_OP_RESUME:    susp_next   = 1'h0;
						default: ;
					endcase
					if (op_polls(op_reg) || op_reg == `FH_OP_AUTOSEL) begin
						// Poll at the target; autoselect reads the code offset
						pins_next  = rd_pins(addr_reg);
						state_next = ST_R_SETUP;
					end else begin
						busy_next = 1'h0;  done_next = 1'h1;  state_next = ST_IDLE;
					end
				end
			end
			ST_R_SETUP: begin
				cnt_next   = `FH_RD_CYC - 3'h1;
				state_next = ST_R_WAIT;
			end
			ST_R_WAIT: begin
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h0) begin
					rdata_next     = dq_in;
					pins_next.ce_n = 1'h1;
					pins_next.oe_n = 1'h1;
					state_next     = ST_R_END;
				end
			end
			ST_R_END: begin
				pins_next  = rd_pins(addr_reg);
				state_next = ST_R_SETUP;
				if (!op_polls(op_reg) || final_reg) begin
					busy_next = 1'h0;  done_next = 1'h1;  sreq_next = 1'h0;
					pins_next = PINS_IDLE;
					state_next = ST_IDLE;
				end else if (sreq_reg && op_sector(op_reg)) begin
					sreq_next  = 1'h0;
					op_next    = `FH_OP_SUSPEND;
					step_next  = 3'h0;
					final_next = 1'h0;
					pins_next  = wr_pins(cmd_cycle(`FH_OP_SUSPEND, 3'h0, byte_reg,
						addr_reg, data_reg));
					state_next = ST_W_SETUP;
				end else if (rdata_reg[`FH_POLL_BIT] == exp_bit) begin
					final_next = 1'h1;
				end else if (limit_reg || poll_reg == POLL_LIMIT) begin
					busy_next = 1'h0;  done_next = 1'h1;  fail_next = 1'h1;
					sreq_next = 1'h0;
					pins_next = PINS_IDLE;
					state_next = ST_IDLE;
				end else begin
					limit_next = rdata_reg[`FH_LIMIT_BIT];
					poll_next  = poll_reg + 32'h0000_0001;
				end
			end
			default: begin
				pins_next  = PINS_IDLE;
				state_next = ST_IDLE;
			end
		endcase
	end
////////////////////////////////////////////////////////////////////////////////
// Registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;   op_reg <= `FH_OP_RESET; step_reg <= 3'h0;
			cnt_reg <= 3'h0;        poll_reg <= '0;         final_reg <= 1'h0;
			limit_reg <= 1'h0;      busy_reg <= 1'h0;       done_reg <= 1'h0;
			fail_reg <= 1'h0;       refused_reg <= 1'h0;    bypass_reg <= 1'h0;
			susp_reg <= 1'h0;       sreq_reg <= 1'h0;       byte_reg <= 1'h0;
			addr_reg <= '0;         data_reg <= '0;         rdata_reg <= '0;
			pins_reg <= PINS_IDLE;  rd_reg <= '0;           wait_reg <= 1'h1;
		end else begin
			state_reg <= state_next; op_reg <= op_next;      step_reg <= step_next;
			cnt_reg <= cnt_next;     poll_reg <= poll_next;  final_reg <= final_next;
			limit_reg <= limit_next; busy_reg <= busy_next;  done_reg <= done_next;
			fail_reg <= fail_next;   refused_reg <= refused_next;
			bypass_reg <= bypass_next; susp_reg <= susp_next; sreq_reg <= sreq_next;
			byte_reg <= byte_next;   addr_reg <= addr_next;  data_reg <= data_next;
			rdata_reg <= rdata_next; pins_reg <= pins_next;  rd_reg <= rd_next;
			wait_reg <= wait_next;
		end
	end
endmodule // flash_host

// ### hw/flash_host_defs.svh
// Constants for the parallel flash command host: offsets, codes, fields and timing
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// Bus widths toward the flash
`define FH_ADDR_W        19
`define FH_DATA_W        16

// Register word offsets on the Avalon port
`define FH_REG_CMD       3'h0
`define FH_REG_CTRL      3'h1
`define FH_REG_ADDR      3'h2
`define FH_REG_DATA      3'h3
`define FH_REG_STATUS    3'h4
`define FH_REG_RDATA     3'h5

// Operation codes written to the command register
`define FH_OP_RESET      4'h0
`define FH_OP_READ       4'h1
`define FH_OP_PROGRAM    4'h2
`define FH_OP_BYP_ENTER  4'h3
`define FH_OP_BYP_PROG   4'h4
`define FH_OP_BYP_EXIT   4'h5
`define FH_OP_SECT_ERASE 4'h6
`define FH_OP_CHIP_ERASE 4'h7
`define FH_OP_SUSPEND    4'h8
`define FH_OP_RESUME     4'h9
`define FH_OP_AUTOSEL    4'hA

// Command bytes placed on the low data byte
`define FH_CD_UNLOCK1    8'hAA
`define FH_CD_UNLOCK2    8'h55
`define FH_CD_RESET      8'hF0
`define FH_CD_PROGRAM    8'hA0
`define FH_CD_BYPASS     8'h20
`define FH_CD_BYP_EXIT1  8'h90
`define FH_CD_BYP_EXIT2  8'h00
`define FH_CD_ERASE_SET  8'h80
`define FH_CD_SECTOR     8'h30
`define FH_CD_CHIP       8'h10
`define FH_CD_SUSPEND    8'hB0
`define FH_CD_RESUME     8'h30
`define FH_CD_AUTOSEL    8'h90
`define FH_CD_UPPER      8'h00

// Unlock addresses for word and byte mode
`define FH_UA1_WORD      19'h0_0555
`define FH_UA2_WORD      19'h0_02AA
`define FH_UA1_BYTE      19'h0_0AAA
`define FH_UA2_BYTE      19'h0_0555
`define FH_ADDR_ANY      19'h0_0000

// Status data bits read back from the flash
`define FH_POLL_BIT      7
`define FH_LIMIT_BIT     5

// Status and control register bit positions
`define FH_ST_BUSY       0
`define FH_ST_DONE       1
`define FH_ST_FAIL       2
`define FH_ST_LIMIT      3
`define FH_ST_REFUSED    4
`define FH_ST_BYPASS     5
`define FH_ST_SUSP       6
`define FH_ST_SUSP_REQ   7
`define FH_CTRL_BYTE     0

// Bus cycle timing in clock cycles, and poll reads before giving up
`define FH_WE_CYC        3'h2
`define FH_RD_CYC        3'h3
`define FH_POLL_LIMIT    32'h0131_2D00

`endif

// ### hw/flash_host_pkg.sv
// Types shared by the flash command host
package flash_host_pkg;
`include "flash_host_defs.svh"

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_W_SETUP, ST_W_LOW, ST_W_HIGH, ST_W_END, ST_R_SETUP, ST_R_WAIT, ST_R_END
	} state_type;

	// One write cycle of a command sequence
	typedef struct packed {
		logic [`FH_ADDR_W-1:0] addr;
		logic [`FH_DATA_W-1:0] data;
	} flash_cycle_type;

	// Every flash pin the host drives
	typedef struct packed {
		logic [`FH_ADDR_W-1:0] addr;
		logic [`FH_DATA_W-1:0] dout;
		logic                  dq_oe;
		logic                  ce_n;
		logic                  we_n;
		logic                  oe_n;
	} flash_pins_type;

	localparam flash_pins_type PINS_IDLE = '{addr: '0, dout: '0, dq_oe: 1'h0,
		ce_n: 1'h1, we_n: 1'h1, oe_n: 1'h1};
endpackage

// ### verification/flash_host_props.sv
// Concurrent checks on the flash host's register bus and flash pins
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_host_props #(
	parameter int unsigned POLL_LIMIT = 20 // Same poll ceiling as the host
) (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic [2:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [18:0] flash_addr,
	input wire logic [15:0] dq_in,
	input wire logic [15:0] dq_out,
	input wire logic        dq_oe,
	input wire logic        ce_n,
	input wire logic        we_n,
	input wire logic        oe_n
);
	default clocking dc @(posedge clock); endclocking
	default disable iff (!reset_n);
	// One wait cycle, one acknowledge cycle, never unasked
	wait_once_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer");
	ack_single_a: assert property (!waitrequest |=> waitrequest)
		else $error("long ack");
	ack_cause_a: assert property (!waitrequest |-> $past(read || write))
		else $error("stray ack");
	// Strobe only inside chip select, with the data bus driven
	strobe_inside_a: assert property (!we_n |-> !ce_n && dq_oe && oe_n)
		else $error("stray strobe");
	we_width_a: assert property ($fell(we_n) |=> !we_n ##1 we_n)
		else $error("strobe width");
	// Address settled before the fall, data still held at the rise
	addr_hold_a: assert property (!we_n || $rose(we_n) |-> $stable(flash_addr))
		else $error("address moved");
	data_hold_a: assert property ($rose(we_n) |-> $stable(dq_out) && !ce_n && dq_oe)
		else $error("data dropped");
	// Reads never fight the host's own drivers
	read_turn_a: assert property (!oe_n |-> !dq_oe && we_n && !ce_n)
		else $error("bus fight");
	read_len_a: assert property ($fell(oe_n) |-> !oe_n [*3])
		else $error("short read");
	cover property ($fell(we_n));
	cover property ($fell(oe_n));
	cover property (read && !waitrequest && address == `FH_REG_STATUS);
endmodule // flash_host_props

bind flash_host flash_host_props #(.POLL_LIMIT(POLL_LIMIT)) props_u (
	.clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
	.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));

// ### verification/flash_model.sv
// Behavioural parallel NOR flash answering the host's command sequences
`timescale 1ns/1ps
module flash_model #(
	parameter int          PROG_NS  = 1000,     // Program time
	parameter int          ERASE_NS = 3000,     // Sector erase time
	parameter int          GUARD_NS = 2000,     // All-protected erase
	parameter int          CHIP_NS  = 20000,    // Outlasts host poll
	parameter logic [5:0]  PROT_SEC = 6'h3F,    // The one protected sector
	parameter logic [15:0] MAKER_ID = 16'h00A5, // Arbitrary value
	parameter logic [15:0] PART_ID  = 16'h005C  // Arbitrary value
) (
	input  wire logic [18:0] flash_addr,
	input  wire logic [15:0] dq_out,
	input  wire logic        dq_oe,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	output logic      [15:0] dq_in
);
	logic [15:0] mem [int];       // Absent cells read erased
	logic [18:0] lat_a, pa;       // Latched address, program location
	logic [15:0] pv, rv;          // Program value, value a read sees
	logic [15:0] last = 16'h0000; // Last value on the bus
	logic [5:0]  es;              // Sector under erase
	int          n, pleft, eleft; // Sequence step, busy times in ns
	bit          act, byp, asel, susp, chip;
	initial dq_in = 16'hFFFF;
	// Address taken as the later strobe falls
	always @(negedge we_n or negedge ce_n)
		if (!we_n && !ce_n) begin
			lat_a = flash_addr;
			act = 1'b1;
		end
	// Data taken as the first strobe rises; status valid at once
	always @(posedge we_n or posedge ce_n)
		if (act) begin
			act = 1'b0;
			decode(lat_a, dq_out);
		end
	task automatic decode(input logic [18:0] a, input logic [15:0] w);
		logic [7:0] d;
		logic u1, u2;
		d = w[7:0]; // Upper byte and upper address ignored
		u1 = a[10:0] == 11'h555;
		u2 = a[10:0] == 11'h2AA;
		if (pleft > 0 || chip && eleft > 0) return;
		if (eleft > 0 && !susp) begin
			susp = d == 8'hB0;
			return;
		end
		if (d == 8'hF0) begin
			n = 0;
			asel = 1'b0;
			return;
		end
		case (n)
			0: if (byp && d == 8'hA0) n = 3;
				else if (byp && d == 8'h90) n = 7;
				else if (susp && d == 8'h30) susp = 1'b0;
				else n = (u1 && d == 8'hAA) ? 1 : 0;
			1: n = (u2 && d == 8'h55) ? 2 : 0;
			2: begin
				n = !u1 ? 0 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
				byp |= u1 && d == 8'h20;
				asel |= u1 && d == 8'h90; // Allowed while suspended
			end
			3: begin // Nothing written in a protected sector
				n = 0;
				pa = a;
				pv = w;
				pleft = PROG_NS;
				if (a[17:12] != PROT_SEC) mem[a] = w;
			end
			4: n = (u1 && d == 8'hAA) ? 5 : 0;
			5: n = (u2 && d == 8'h55) ? 6 : 0;
			6: begin // Sector from address bits 17 to 12
				n = 0;
				es = a[17:12];
				chip = d == 8'h10;
				if (chip) mem.delete();
				if (chip) eleft = CHIP_NS;
				if (d == 8'h30) eleft = es == PROT_SEC ? GUARD_NS : ERASE_NS;
				if (d == 8'h30 && es != PROT_SEC) foreach (mem[k]) if (k[17:12] == es) mem[k] = 16'hFFFF;
			end
			default: begin
				n = 0;
				byp &= d != 8'h00;
			end
		endcase
	endtask
	// Internal timers; a suspended erase holds its count
	always #100 begin
		if (pleft > 0) pleft -= 100;
		if (eleft > 0 && !susp) eleft -= 100;
	end
	// Read path; a released bus shows the inverse of the last value
	always @(flash_addr or ce_n or oe_n or pleft or eleft or susp or asel or byp) begin
		if (pleft > 0 && flash_addr == pa) rv = {8'h00, ~pv[7], 7'h00};
		else if (eleft > 0 && (chip || flash_addr[17:12] == es)) rv = {8'h00, susp, 7'h00};
		else if (asel && flash_addr[7:0] == 8'h00) rv = MAKER_ID;
		else if (asel && flash_addr[7:0] == 8'h01) rv = PART_ID;
		else if (asel && flash_addr[7:0] == 8'h02) rv = {15'h0000, flash_addr[17:12] == PROT_SEC};
		else rv = mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF;
		if (!ce_n && !oe_n) last = rv;
		dq_in = (!ce_n && !oe_n) ? rv : ~last;
	end
endmodule // flash_model

// ### verification/testbench.sv
// Self-checking bench: host driven over its register bus against the flash model
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module testbench;
	localparam logic [15:0] maker_id = 16'h00A5; // Arbitrary value
	localparam logic [15:0] part_id  = 16'h005C; // Arbitrary value
	logic        clock = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0;
	logic [2:0]  address = 3'h0;
	logic [31:0] writedata = 32'h0000_0000, readdata, s;
	logic        waitrequest, dq_oe, ce_n, we_n, oe_n;
	logic [18:0] flash_addr;
	logic [15:0] dq_in, dq_out;
	int          n_fail = 0, total_checks = 0, cyc = 0, k;
	typedef struct packed {
		logic [3:0] op; logic [18:0] ad; logic [15:0] da;
		logic [7:0] sm; logic [7:0] sv; logic ck; logic [15:0] rd;
	} row_type; // Command, target, value, status mask/expect, read-back
	row_type rows [21] = '{
		'{4'h2, 19'h0_0100, 16'h1234, 8'h17, 8'h02, 1'b1, 16'h1234},
		'{4'h2, 19'h0_1005, 16'h0042, 8'h17, 8'h02, 1'b1, 16'h0042},
		'{4'h2, 19'h0_2004, 16'h5A5A, 8'h17, 8'h02, 1'b1, 16'h5A5A},
		'{4'hA, 19'h0_0000, 16'h0000, 8'h15, 8'h00, 1'b1, maker_id},
		'{4'hA, 19'h0_0001, 16'h0000, 8'h15, 8'h00, 1'b1, part_id},
		'{4'hA, 19'h3_F002, 16'h0000, 8'h15, 8'h00, 1'b1, 16'h0001},
		'{4'hA, 19'h0_1002, 16'h0000, 8'h15, 8'h00, 1'b1, 16'h0000},
		'{4'h0, 19'h0_0000, 16'h0000, 8'h15, 8'h00, 1'b0, 16'h0000},
		'{4'h1, 19'h0_0100, 16'h0000, 8'h15, 8'h00, 1'b1, 16'h1234},
		'{4'h4, 19'h0_0200, 16'hBEEF, 8'h10, 8'h10, 1'b0, 16'h0000},
		'{4'h3, 19'h0_0000, 16'h0000, 8'h20, 8'h20, 1'b0, 16'h0000},
		'{4'h4, 19'h0_0200, 16'hBEEF, 8'h17, 8'h02, 1'b1, 16'hBEEF},
		'{4'h5, 19'h0_0000, 16'h0000, 8'h20, 8'h00, 1'b0, 16'h0000},
		'{4'h1, 19'h0_0200, 16'h0000, 8'h15, 8'h00, 1'b1, 16'hBEEF},
		'{4'h2, 19'h3_F010, 16'h0000, 8'h05, 8'h04, 1'b0, 16'h0000},
		'{4'h1, 19'h3_F010, 16'h0000, 8'h15, 8'h00, 1'b1, 16'hFFFF},
		'{4'h6, 19'h0_1000, 16'h0000, 8'h17, 8'h02, 1'b0, 16'h0000},
		'{4'h1, 19'h0_1005, 16'h0000, 8'h15, 8'h00, 1'b1, 16'hFFFF},
		'{4'h6, 19'h3_F000, 16'h0000, 8'h17, 8'h02, 1'b0, 16'h0000},
		'{4'h8, 19'h0_0000, 16'h0000, 8'h10, 8'h10, 1'b0, 16'h0000},
		'{4'h9, 19'h0_0000, 16'h0000, 8'h10, 8'h10, 1'b0, 16'h0000}};
	initial forever #25 clock = ~clock;
	flash_host #(.POLL_LIMIT(20)) dut_u (.clock(clock), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
	flash_model #(.MAKER_ID(maker_id), .PART_ID(part_id)) model_u (.flash_addr(flash_addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_in(dq_in));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do @(posedge clock); while (waitrequest !== 1'b0);
		s = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	// Status polled until busy drops
	task automatic run(input logic [3:0] c, input logic [18:0] a, input logic [15:0] d);
		bus(1'b1, `FH_REG_ADDR, {13'h0000, a});
		bus(1'b1, `FH_REG_DATA, {16'h0000, d});
		bus(1'b1, `FH_REG_CMD, {28'h000_0000, c});
		for (int i = 0; i < 2000 && (i == 0 || s[`FH_ST_BUSY] !== 1'b0); i++)
			bus(1'b0, `FH_REG_STATUS, 32'h0000_0000);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (6) @(posedge clock);
		chk("reset pins", {waitrequest, ce_n, we_n, oe_n, dq_oe, readdata[26:0]}, 32'hF000_0000);
		reset_n <= 1'b1;
		bus(1'b1, `FH_REG_CTRL, 32'h0000_0000); // Word mode
		foreach (rows[i]) begin
			run(rows[i].op, rows[i].ad, rows[i].da);
			chk("status", {24'h00_0000, rows[i].sv}, s & {24'h00_0000, rows[i].sm});
			if (rows[i].ck) bus(1'b0, `FH_REG_RDATA, 32'h0000_0000);
			if (rows[i].ck) chk("rdata", {16'h0000, rows[i].rd}, s);
		end
		bus(1'b1, 3'h7, 32'hFFFF_FFFF);
		bus(1'b0, 3'h7, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, s);
		// Suspend a running sector erase, program elsewhere, then resume
		bus(1'b1, `FH_REG_ADDR, 32'h0000_2000);
		bus(1'b1, `FH_REG_CMD, 32'h0000_0006);
		for (k = 0; k < 400 && oe_n !== 1'b0; k++) @(posedge clock);
		run(4'h8, 19'h0_2000, 16'h0000);
		chk("suspend", 32'h0000_0040, s & 32'h0000_0045);
		run(4'h2, 19'h0_0300, 16'h0077);
		chk("suspended program", 32'h0000_0000, s & 32'h0000_0005);
		run(4'h1, 19'h0_0300, 16'h0000);
		bus(1'b0, `FH_REG_RDATA, 32'h0000_0000);
		chk("suspended read", 32'h0000_0077, s);
		run(4'h9, 19'h0_2000, 16'h0000);
		chk("resume", 32'h0000_0000, s & 32'h0000_0045);
		run(4'h1, 19'h0_2004, 16'h0000);
		bus(1'b0, `FH_REG_RDATA, 32'h0000_0000);
		chk("erased", 32'h0000_FFFF, s);
		// Chip erase outlasts the poll ceiling
		bus(1'b1, `FH_REG_CMD, 32'h0000_0007);
		for (k = 0; k < 400 && oe_n !== 1'b0; k++) @(posedge clock);
		bus(1'b1, `FH_REG_CMD, 32'h0000_0008);
		bus(1'b0, `FH_REG_STATUS, 32'h0000_0000);
		chk("busy refusal", 32'h0000_0011, s & 32'h0000_0011);
		run(4'h2, 19'h0_0400, 16'h0000);
		chk("chip erase", 32'h0000_0004, s & 32'h0000_0005);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		chk("second reset", {waitrequest, ce_n, we_n, oe_n, dq_oe, readdata[26:0]}, 32'hF000_0000);
		tally_and_finish;
	end
endmodule // testbench
